// file: rtl/loop_tuning_select.sv
// Damping factor and second detector gain selection for one loop.
// Assumes register fields and loop state arrive on the caller's clock.
`timescale 1ns/1ps
module loop_tuning_select
    import pll_tune_pkg::*;
(
    // Register fields
    input  wire logic [7:0] damping_reg,
    input  wire logic [7:0] gain_reg,
    // Loop state
    input  wire logic [1:0] bandwidth,
    input  wire logic [1:0] lock_mode,
    // Selections
    output logic [7:0]      damping_factor,
    output logic            detector_used,
    output logic [2:0]      detector_gain
);

    // ****************************************
    // Damping lookup
    // ****************************************
    function automatic logic [7:0] damping_lookup(input logic [2:0] code,
                                                  input logic [1:0] bw);
        logic [7:0] value;
        value = DAMP_NONE;
        case (code)
            DCODE_1P2: value = DAMP_1P2;
            DCODE_2P5: value = DAMP_2P5;
            DCODE_5:   value = DAMP_5;
            DCODE_MID: value = (bw == BW_35HZ || bw == BW_70HZ) ? DAMP_10 : DAMP_5;
            DCODE_TOP: begin
                if (bw == BW_70HZ) begin
                    value = DAMP_20;
                end else if (bw == BW_35HZ) begin
                    value = DAMP_10;
                end else begin
                    value = DAMP_5;
                end
            end
            default:   value = DAMP_NONE;
        endcase
        return value;
    endfunction : damping_lookup

    // ****************************************
    // Selection
    // ****************************************
    logic auto_gain_on;
    assign auto_gain_on = gain_reg[AUTO_GAIN_BIT];

    always_comb begin
        damping_factor = damping_lookup(damping_reg[DAMP_CODE_LSB +: FIELD3_W],
                                        bandwidth);
        detector_used  = auto_gain_on;
        detector_gain  = gain_reg[DIGITAL_LSB +: FIELD3_W];
        if (auto_gain_on) begin
            if (lock_mode == LOCK_ANALOG_LOW) begin
                detector_gain = damping_reg[LOW_RATE_LSB +: FIELD3_W];
            end else if (lock_mode == LOCK_ANALOG_HIGH) begin
                detector_gain = gain_reg[HIGH_RATE_LSB +: FIELD3_W];
            end
        end
    end

endmodule : loop_tuning_select

// file: rtl/pll_loop_tuning_registers.sv
// Tuning register set for the primary and secondary loops.
// Assumes the serial port decoder and loop logic share this clock.
//
// Behaviour
// - Codes 001/010/011 give 1.2, 2.5, 5
// - Code 100 gives 5, 10, 10
// - Code 101 gives 5, 10, 20
// - Primary loop damping field, same mapping
// - Auto gain off: second detector unused
// - Auto gain on: gain from locking mode
// - Analog high rate uses gain bits 6:4
// - Digital or auto off uses bits 2:0
// - Phase offset is low and high byte
// - Locked loop ramps offset unless disabled
// - Offset ignored while build-out enabled
// - Build-out trim register, top bits unused
// - Each loop's own bandwidth selects its damping column
`timescale 1ns/1ps
module pll_loop_tuning_registers
    import pll_tune_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,

    // Register port from serial decoder
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,

    // Settings held elsewhere in the device
    input  wire logic        buildout_enabled,
    input  wire logic        ramp_disabled,

    // Secondary loop state
    input  wire logic [1:0]  secondary_bandwidth,
    input  wire logic [1:0]  secondary_lock_mode,

    // Primary loop state
    input  wire logic [1:0]  primary_bandwidth,
    input  wire logic [1:0]  primary_lock_mode,
    input  wire logic        primary_locked,

    // Secondary loop tuning
    output logic [7:0]       secondary_damping_factor,
    output logic             secondary_detector_used,
    output logic [2:0]       secondary_detector_gain,

    // Primary loop tuning
    output logic [7:0]       primary_damping_factor,
    output logic             primary_detector_used,
    output logic [2:0]       primary_detector_gain,

    // Phase offset and build-out trim
    output logic [15:0]      applied_phase_offset,
    output logic [5:0]       buildout_mean_error_trim
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0]  aux_loop_damping_cfg;
        logic [7:0]  main_loop_damping_cfg;
        logic [7:0]  aux_loop_detector_gain_cfg;
        logic [7:0]  main_loop_detector_gain_cfg;
        logic [7:0]  output_phase_offset_low;
        logic [7:0]  output_phase_offset_high;
        logic [7:0]  buildout_time_error_offset;

        logic [15:0] ramp_offset;
        logic [15:0] ramp_count;
        logic [7:0]  rdata;
        logic        rvalid;

        logic [7:0]  sec_damping;
        logic        sec_used;
        logic [2:0]  sec_gain;
        logic [7:0]  pri_damping;
        logic        pri_used;
        logic [2:0]  pri_gain;
        logic [15:0] offset_out;
        logic [5:0]  trim_out;
    } state_t;

    // ****************************************
    // Local constants
    // ****************************************
    localparam logic [15:0] RAMP_COUNT_LAST = 16'(RAMP_STEP_CYCLES - 1);
    localparam logic [15:0] OFFSET_ZERO     = 16'h0000;
    localparam logic [15:0] COUNT_ZERO      = 16'h0000;
    localparam logic [15:0] COUNT_ONE       = 16'h0001;
    localparam int          TRIM_W          = 6;

    state_t state;
    state_t next_state;

    // ****************************************
    // Selector outputs
    // ****************************************
    logic [7:0] sec_damping_sel;
    logic       sec_used_sel;
    logic [2:0] sec_gain_sel;
    logic [7:0] pri_damping_sel;
    logic       pri_used_sel;
    logic [2:0] pri_gain_sel;

    loop_tuning_select secondary_select (
        .damping_reg    (state.aux_loop_damping_cfg),
        .gain_reg       (state.aux_loop_detector_gain_cfg),
        .bandwidth      (secondary_bandwidth),
        .lock_mode      (secondary_lock_mode),
        .damping_factor (sec_damping_sel),
        .detector_used  (sec_used_sel),
        .detector_gain  (sec_gain_sel)
    );

    loop_tuning_select primary_select (
        .damping_reg    (state.main_loop_damping_cfg),
        .gain_reg       (state.main_loop_detector_gain_cfg),
        .bandwidth      (primary_bandwidth),
        .lock_mode      (primary_lock_mode),
        .damping_factor (pri_damping_sel),
        .detector_used  (pri_used_sel),
        .detector_gain  (pri_gain_sel)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] masked_write(input logic [7:0] data,
                                                input logic [7:0] mask);
        return data & mask;
    endfunction : masked_write

    function automatic logic [15:0] step_toward(input logic [15:0] from,
                                                input logic [15:0] to);
        logic [15:0] result;
        result = from;
        if ($signed(to) > $signed(from)) begin
            result = from + RAMP_STEP;
        end else if ($signed(to) < $signed(from)) begin
            result = from - RAMP_STEP;
        end
        return result;
    endfunction : step_toward

    // ****************************************
    // Address decode
    // ****************************************
    typedef struct packed {
        logic aux_damping;
        logic main_damping;
        logic aux_gain;
        logic main_gain;
        logic offset_low;
        logic offset_high;
        logic trim;
    } reg_hit_t;

    function automatic reg_hit_t decode_addr(input logic [7:0] addr);
        reg_hit_t result;
        result.aux_damping  = (addr == ADDR_AUX_DAMPING);
        result.main_damping = (addr == ADDR_MAIN_DAMPING);
        result.aux_gain     = (addr == ADDR_AUX_GAIN);
        result.main_gain    = (addr == ADDR_MAIN_GAIN);
        result.offset_low   = (addr == ADDR_OFFSET_LOW);
        result.offset_high  = (addr == ADDR_OFFSET_HIGH);
        result.trim         = (addr == ADDR_BUILDOUT_TRIM);
        return result;
    endfunction : decode_addr

    reg_hit_t hit;
    assign hit = decode_addr(reg_addr);

    logic [15:0] target_offset;
    assign target_offset = {state.output_phase_offset_high,
                            state.output_phase_offset_low};

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_state = state;

        // Register writes
        if (reg_write) begin
            if (hit.aux_damping) begin
                next_state.aux_loop_damping_cfg = masked_write(reg_wdata, MASK_DAMPING);
            end else if (hit.main_damping) begin
                next_state.main_loop_damping_cfg = masked_write(reg_wdata, MASK_DAMPING);
            end else if (hit.aux_gain) begin
                next_state.aux_loop_detector_gain_cfg = masked_write(reg_wdata, MASK_GAIN);
            end else if (hit.main_gain) begin
                next_state.main_loop_detector_gain_cfg = masked_write(reg_wdata, MASK_GAIN);
            end else if (hit.offset_low) begin
                next_state.output_phase_offset_low = masked_write(reg_wdata, MASK_OFFSET);
            end else if (hit.offset_high) begin
                next_state.output_phase_offset_high = masked_write(reg_wdata, MASK_OFFSET);
            end else if (hit.trim) begin
                next_state.buildout_time_error_offset =
                    masked_write(reg_wdata, MASK_TRIM);
            end
        end

        // Register reads, unmapped read as zero
        next_state.rvalid = reg_read;
        if (reg_read) begin
            if (hit.aux_damping) begin
                next_state.rdata = state.aux_loop_damping_cfg;
            end else if (hit.main_damping) begin
                next_state.rdata = state.main_loop_damping_cfg;
            end else if (hit.aux_gain) begin
                next_state.rdata = state.aux_loop_detector_gain_cfg;
            end else if (hit.main_gain) begin
                next_state.rdata = state.main_loop_detector_gain_cfg;
            end else if (hit.offset_low) begin
                next_state.rdata = state.output_phase_offset_low;
            end else if (hit.offset_high) begin
                next_state.rdata = state.output_phase_offset_high;
            end else if (hit.trim) begin
                next_state.rdata = state.buildout_time_error_offset;
            end else begin
                next_state.rdata = RST_OFFSET;
            end
        end

        // Offset ramp
        if (state.ramp_offset == target_offset) begin
            next_state.ramp_count = '0;
        end else if (primary_locked && !ramp_disabled) begin
            if (state.ramp_count == RAMP_COUNT_LAST) begin
                next_state.ramp_count  = '0;
                next_state.ramp_offset = step_toward(state.ramp_offset, target_offset);
            end else begin
                next_state.ramp_count = state.ramp_count + COUNT_ONE;
            end
        end else begin
            next_state.ramp_count  = '0;
            next_state.ramp_offset = target_offset;
        end

        // Registered outputs
        next_state.sec_damping = sec_damping_sel;
        next_state.sec_used    = sec_used_sel;
        next_state.sec_gain    = sec_gain_sel;
        next_state.pri_damping = pri_damping_sel;
        next_state.pri_used    = pri_used_sel;
        next_state.pri_gain    = pri_gain_sel;
        next_state.offset_out  = buildout_enabled ? OFFSET_ZERO : state.ramp_offset;
        next_state.trim_out    = state.buildout_time_error_offset[TRIM_W-1:0];
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            state.aux_loop_damping_cfg        <= RST_DAMPING;
            state.main_loop_damping_cfg       <= RST_DAMPING;
            state.aux_loop_detector_gain_cfg  <= RST_GAIN;
            state.main_loop_detector_gain_cfg <= RST_GAIN;
            state.output_phase_offset_low     <= RST_OFFSET;
            state.output_phase_offset_high    <= RST_OFFSET;
            state.buildout_time_error_offset  <= RST_TRIM;

            state.ramp_offset                 <= OFFSET_ZERO;
            state.ramp_count                  <= COUNT_ZERO;
            state.rdata                       <= 8'h00;
            state.rvalid                      <= 1'b0;

            state.sec_damping                 <= DAMP_NONE;
            state.sec_used                    <= 1'b0;
            state.sec_gain                    <= 3'h0;
            state.pri_damping                 <= DAMP_NONE;
            state.pri_used                    <= 1'b0;
            state.pri_gain                    <= 3'h0;
            state.offset_out                  <= OFFSET_ZERO;
            state.trim_out                    <= 6'h00;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata                = state.rdata;
    assign reg_rvalid               = state.rvalid;

    assign secondary_damping_factor = state.sec_damping;
    assign secondary_detector_used  = state.sec_used;
    assign secondary_detector_gain  = state.sec_gain;
    assign primary_damping_factor   = state.pri_damping;
    assign primary_detector_used    = state.pri_used;
    assign primary_detector_gain    = state.pri_gain;

    assign applied_phase_offset     = state.offset_out;
    assign buildout_mean_error_trim = state.trim_out;

endmodule : pll_loop_tuning_registers

// file: rtl/pll_tune_pkg.sv
// Constants, register map and types for the loop tuning register set.
// Assumes a single 200 MHz clock shared by all users of this package.
package pll_tune_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] ADDR_AUX_DAMPING   = 8'h6A;
    localparam logic [7:0] ADDR_MAIN_DAMPING  = 8'h6B;
    localparam logic [7:0] ADDR_AUX_GAIN      = 8'h6C;
    localparam logic [7:0] ADDR_MAIN_GAIN     = 8'h6D;
    localparam logic [7:0] ADDR_OFFSET_LOW    = 8'h70;
    localparam logic [7:0] ADDR_OFFSET_HIGH   = 8'h71;
    localparam logic [7:0] ADDR_BUILDOUT_TRIM = 8'h72;

    // ****************************************
    // Reset values and writable bit masks
    // ****************************************
    localparam logic [7:0] RST_DAMPING   = 8'h13;
    localparam logic [7:0] RST_GAIN      = 8'hC2;
    localparam logic [7:0] RST_OFFSET    = 8'h00;
    localparam logic [7:0] RST_TRIM      = 8'h00;
    localparam logic [7:0] MASK_DAMPING  = 8'h77;
    localparam logic [7:0] MASK_GAIN     = 8'hF7;
    localparam logic [7:0] MASK_OFFSET   = 8'hFF;
    localparam logic [7:0] MASK_TRIM     = 8'h3F;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int DAMP_CODE_LSB   = 0;
    localparam int LOW_RATE_LSB    = 4;
    localparam int AUTO_GAIN_BIT   = 7;
    localparam int HIGH_RATE_LSB   = 4;
    localparam int DIGITAL_LSB     = 0;
    localparam int FIELD3_W        = 3;

    // ****************************************
    // Damping factor in tenths
    // ****************************************
    localparam logic [7:0] DAMP_1P2  = 8'h0C;
    localparam logic [7:0] DAMP_2P5  = 8'h19;
    localparam logic [7:0] DAMP_5    = 8'h32;
    localparam logic [7:0] DAMP_10   = 8'h64;
    localparam logic [7:0] DAMP_20   = 8'hC8;
    localparam logic [7:0] DAMP_NONE = 8'h00;

    // ****************************************
    // Ramp timing
    // ****************************************
    localparam int CLOCK_PERIOD_PS   = 5000;
    localparam int RAMP_STEP_TIME_NS = 1000;
    localparam int RAMP_STEP_CYCLES  =
        (RAMP_STEP_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam logic [15:0] RAMP_STEP = 16'h0001;

    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [1:0] {
        BW_18HZ   = 2'h0,
        BW_35HZ   = 2'h1,
        BW_70HZ   = 2'h2,
        BW_UNUSED = 2'h3
    } bandwidth_t;

    typedef enum logic [1:0] {
        LOCK_DIGITAL     = 2'h0,
        LOCK_ANALOG_HIGH = 2'h1,
        LOCK_ANALOG_LOW  = 2'h2
    } lock_mode_t;

    typedef enum logic [2:0] {
        DCODE_1P2 = 3'h1,
        DCODE_2P5 = 3'h2,
        DCODE_5   = 3'h3,
        DCODE_MID = 3'h4,
        DCODE_TOP = 3'h5
    } damp_code_t;

endpackage : pll_tune_pkg

// file: testbench/pll_loop_tuning_registers_chk.sv
// Checker of the loop tuning register set, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pll_loop_tuning_registers_chk
    import pll_tune_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    // Loop state
    input wire logic        buildout_enabled,
    input wire logic        ramp_disabled,
    input wire logic        primary_locked,
    input wire logic [1:0]  secondary_bandwidth,
    input wire logic [1:0]  primary_bandwidth,
    // Tuning outputs
    input wire logic [7:0]  secondary_damping_factor,
    input wire logic        secondary_detector_used,
    input wire logic [7:0]  primary_damping_factor,
    input wire logic        primary_detector_used,
    input wire logic [2:0]  primary_detector_gain,
    input wire logic [15:0] applied_phase_offset,
    input wire logic [5:0]  buildout_mean_error_trim
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic addr_mapped;
    logic ramp_ok;
    assign addr_mapped = reg_addr inside {ADDR_AUX_DAMPING, ADDR_MAIN_DAMPING, ADDR_AUX_GAIN,
        ADDR_MAIN_GAIN, ADDR_OFFSET_LOW, ADDR_OFFSET_HIGH, ADDR_BUILDOUT_TRIM};
    assign ramp_ok = primary_locked && !ramp_disabled && !buildout_enabled;
    // ****************************************
    // Properties
    // ****************************************
    property p_defaults;
        $fell(rst) |=> primary_damping_factor == DAMP_5 && secondary_detector_used;
    endproperty
    a_defaults: assert property (p_defaults) else $error("bad outputs after reset");
    property p_unmapped;
        reg_read && !addr_mapped |=> reg_rvalid && reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_trim;
        reg_write && reg_addr == ADDR_BUILDOUT_TRIM ##1 !reg_write
            |=> {2'h0, buildout_mean_error_trim} == ($past(reg_wdata, 2) & 8'h3F);
    endproperty
    a_trim: assert property (p_trim) else $error("trim output wrong");
    property p_gain_off;
        reg_write && reg_addr == ADDR_MAIN_GAIN && !reg_wdata[7] ##1 !reg_write
            |=> !primary_detector_used
            && {5'h00, primary_detector_gain} == ($past(reg_wdata, 2) & 8'h07);
    endproperty
    a_gain_off: assert property (p_gain_off) else $error("auto off gain wrong");
    property p_used;
        reg_write && reg_addr == ADDR_AUX_GAIN ##1 !reg_write
            |=> {secondary_detector_used, 7'h00} == ($past(reg_wdata, 2) & 8'h80);
    endproperty
    a_used: assert property (p_used) else $error("detector use wrong");
    property p_aux_top;
        secondary_damping_factor == DAMP_20 && $stable(secondary_bandwidth)
            |-> $past(secondary_bandwidth) == BW_70HZ;
    endproperty
    a_aux_top: assert property (p_aux_top) else $error("aux damping 20 off 70 Hz");
    property p_main_top;
        primary_damping_factor == DAMP_20 && $stable(primary_bandwidth)
            |-> $past(primary_bandwidth) == BW_70HZ;
    endproperty
    a_main_top: assert property (p_main_top) else $error("main damping 20 off 70 Hz");
    property p_buildout;
        $past(buildout_enabled) |-> applied_phase_offset == 16'h0000;
    endproperty
    a_buildout: assert property (p_buildout) else $error("offset not zero");
    property p_ramp;
        ramp_ok [*3] |=> applied_phase_offset == $past(applied_phase_offset)
            || applied_phase_offset == $past(applied_phase_offset) + 16'h0001
            || applied_phase_offset == $past(applied_phase_offset) - 16'h0001;
    endproperty
    a_ramp: assert property (p_ramp) else $error("offset jumped while ramping");
    c_read: cover property (reg_rvalid && reg_rdata == 8'h77);
    c_step: cover property (ramp_ok && $changed(applied_phase_offset));
    c_buildout: cover property (buildout_enabled && primary_locked);
endmodule : pll_loop_tuning_registers_chk

bind pll_loop_tuning_registers pll_loop_tuning_registers_chk i_chk (.*);

// file: testbench/pll_loop_tuning_registers_tb.sv
// Self-checking bench of the loop tuning register set.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ps
module pll_loop_tuning_registers_tb import pll_tune_pkg::*;;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        buildout_enabled = 1'b0;
    logic        ramp_disabled = 1'b0;
    logic [1:0]  secondary_bandwidth = 2'h0;
    logic [1:0]  secondary_lock_mode = 2'h0;
    logic [1:0]  primary_bandwidth = 2'h0;
    logic [1:0]  primary_lock_mode = 2'h0;
    logic        primary_locked = 1'b0;
    logic [7:0]  secondary_damping_factor;
    logic        secondary_detector_used;
    logic [2:0]  secondary_detector_gain;
    logic [7:0]  primary_damping_factor;
    logic        primary_detector_used;
    logic [2:0]  primary_detector_gain;
    logic [15:0] applied_phase_offset;
    logic [5:0]  buildout_mean_error_trim;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cycles = 0;
    typedef struct packed {
        logic [7:0] damp;
        logic [7:0] gain;
        logic [1:0] bw;
        logic [1:0] mode;
        logic [7:0] factor;
        logic       used;
        logic [2:0] pd_gain;
    } row_t;
    row_t rows [11] = '{
        '{8'h51, 8'hE1, 2'h0, 2'h0, DAMP_1P2, 1'b1, 3'h1},
        '{8'h52, 8'hE1, 2'h1, 2'h1, DAMP_2P5, 1'b1, 3'h6},
        '{8'h53, 8'hE1, 2'h2, 2'h2, DAMP_5, 1'b1, 3'h5},
        '{8'h54, 8'hE1, 2'h0, 2'h0, DAMP_5, 1'b1, 3'h1},
        '{8'h54, 8'hE1, 2'h1, 2'h1, DAMP_10, 1'b1, 3'h6},
        '{8'h54, 8'hE1, 2'h2, 2'h2, DAMP_10, 1'b1, 3'h5},
        '{8'h55, 8'hE1, 2'h0, 2'h1, DAMP_5, 1'b1, 3'h6},
        '{8'h35, 8'hE1, 2'h1, 2'h2, DAMP_10, 1'b1, 3'h3},
        '{8'h55, 8'hE1, 2'h2, 2'h0, DAMP_20, 1'b1, 3'h1},
        '{8'h55, 8'h61, 2'h2, 2'h2, DAMP_20, 1'b0, 3'h1},
        '{8'h55, 8'hE1, 2'h3, 2'h0, DAMP_5, 1'b1, 3'h1}
    };

    pll_loop_tuning_registers i_dut (.*);

    always #2.5 clock = ~clock;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        chk("read valid", 16'h0001, 16'(reg_rvalid));
        chk("read data", 16'(exp), 16'(reg_rdata));
    endtask : rdchk

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (2) @(negedge clock);
        rst = 1'b0;
        foreach (rows[i]) begin
            wr(ADDR_AUX_DAMPING, rows[i].damp);
            wr(ADDR_MAIN_DAMPING, rows[i].damp);
            wr(ADDR_AUX_GAIN, rows[i].gain);
            wr(ADDR_MAIN_GAIN, rows[i].gain);
            secondary_bandwidth = rows[i].bw;
            primary_bandwidth = rows[i].bw;
            secondary_lock_mode = rows[i].mode;
            primary_lock_mode = rows[i].mode;
            repeat (3) @(negedge clock);
            chk("aux damping", 16'(rows[i].factor), 16'(secondary_damping_factor));
            chk("main damping", 16'(rows[i].factor), 16'(primary_damping_factor));
            chk("aux used", 16'(rows[i].used), 16'(secondary_detector_used));
            chk("main used", 16'(rows[i].used), 16'(primary_detector_used));
            chk("aux gain", 16'(rows[i].pd_gain), 16'(secondary_detector_gain));
            chk("main gain", 16'(rows[i].pd_gain), 16'(primary_detector_gain));
            rdchk(ADDR_MAIN_DAMPING, rows[i].damp);
        end
        wr(ADDR_AUX_DAMPING, 8'hFF);
        wr(ADDR_AUX_GAIN, 8'hFF);
        wr(ADDR_BUILDOUT_TRIM, 8'hFF);
        wr(8'h73, 8'hFF);
        rdchk(ADDR_AUX_DAMPING, 8'h77);
        rdchk(ADDR_AUX_GAIN, 8'hF7);
        rdchk(ADDR_BUILDOUT_TRIM, 8'h3F);
        rdchk(8'h73, 8'h00);
        chk("trim", 16'h003F, 16'(buildout_mean_error_trim));
        wr(ADDR_OFFSET_LOW, 8'h34);
        wr(ADDR_OFFSET_HIGH, 8'h12);
        repeat (3) @(negedge clock);
        chk("offset", 16'h1234, applied_phase_offset);
        buildout_enabled = 1'b1;
        repeat (2) @(negedge clock);
        chk("offset", 16'h0000, applied_phase_offset);
        buildout_enabled = 1'b0;
        primary_locked = 1'b1;
        repeat (3) @(negedge clock);
        chk("offset", 16'h1234, applied_phase_offset);
        wr(ADDR_OFFSET_LOW, 8'h36);
        repeat (3) @(negedge clock);
        chk("offset", 16'h1234, applied_phase_offset);
        repeat (450) @(negedge clock);
        chk("offset", 16'h1236, applied_phase_offset);
        wr(ADDR_OFFSET_LOW, 8'h35);
        repeat (205) @(negedge clock);
        chk("offset", 16'h1235, applied_phase_offset);
        ramp_disabled = 1'b1;
        wr(ADDR_OFFSET_LOW, 8'h00);
        repeat (3) @(negedge clock);
        chk("offset", 16'h1200, applied_phase_offset);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        rdchk(ADDR_AUX_DAMPING, 8'h13);
        rdchk(ADDR_MAIN_DAMPING, 8'h13);
        rdchk(ADDR_AUX_GAIN, 8'hC2);
        rdchk(ADDR_MAIN_GAIN, 8'hC2);
        rdchk(ADDR_OFFSET_LOW, 8'h00);
        rdchk(ADDR_OFFSET_HIGH, 8'h00);
        rdchk(ADDR_BUILDOUT_TRIM, 8'h00);
        chk("main damping", 16'(DAMP_5), 16'(primary_damping_factor));
        chk("main gain", 16'h0002, 16'(primary_detector_gain));
        chk("offset", 16'h0000, applied_phase_offset);
        print_verdict();
    end
endmodule : pll_loop_tuning_registers_tb
